// ===== hdl/bank_sequencer.sv
`timescale 1ns/1ns
module bank_sequencer
  import led_bank_pkg::*;
(
  input  wire logic       ref_clk_in,     // system clock
  input  wire logic       sys_rst_in,     // async reset, high
  input  wire logic       step_in,        // intensity update pulse
  input  wire logic       restart_in,     // restart pulse
  input  wire logic [2:0] start_code_in,  // region to restart at
  input  wire logic       oneshot_in,     // one-shot mode
  input  wire logic [3:0] fade_up_in,     // region durations
  input  wire logic [3:0] full_on_in,
  input  wire logic [3:0] fade_down_in,
  input  wire logic [3:0] off_one_in,
  input  wire logic [3:0] off_two_in,
  input  wire logic [3:0] peak_in,        // chosen peak level
  output logic [3:0]      level_out,      // waveform level
  output logic            stop_out,       // one-shot stop pulse
  output logic            stop_peak_out   // stop level is peak, not off
);
  region_t    region_r, region_nxt;
  logic [7:0] elapsed_r, elapsed_nxt, acc_r, acc_nxt, len;
  logic [3:0] ramp_r, ramp_nxt, ramp_c, level_nxt;
  logic       armed_r, armed_nxt, stop_nxt, stop_peak_nxt;

  function automatic region_t code_region(input logic [2:0] code);
    case (code)
      3'h0: code_region = REG_A1;
      3'h1: code_region = REG_B1;
      3'h2: code_region = REG_C1;
      3'h3: code_region = REG_D;
      3'h4: code_region = REG_A2;
      3'h5: code_region = REG_B2;
      3'h6: code_region = REG_C2;
      default: code_region = REG_E;
    endcase
  endfunction : code_region

  always_comb begin
    region_nxt    = region_r;
    elapsed_nxt   = elapsed_r;
    acc_nxt       = acc_r;
    ramp_nxt      = ramp_r;
    armed_nxt     = armed_r;
    stop_nxt      = 1'b0;
    stop_peak_nxt = stop_peak_out;
    case (region_r)
      REG_A1, REG_A2: len = 8'(fade_up_in * STEPS_PER_CODE);
      REG_B1, REG_B2: len = 8'(full_on_in * STEPS_PER_CODE);
      REG_C1, REG_C2: len = 8'(fade_down_in * STEPS_PER_CODE);
      REG_D:          len = 8'(off_one_in * STEPS_PER_CODE);
      default:        len = 8'(off_two_in * STEPS_PER_CODE);
    endcase
    ramp_c = (ramp_r > peak_in) ? peak_in : ramp_r;
    case (region_r)
      REG_A1, REG_A2: level_nxt = ramp_c;
      REG_B1, REG_B2: level_nxt = peak_in;
      REG_C1, REG_C2: level_nxt = peak_in - ramp_c;
      default:        level_nxt = 4'h0;
    endcase
    if (restart_in) begin
      region_nxt  = code_region(start_code_in);
      elapsed_nxt = 8'h00;
      acc_nxt     = 8'h00;
      ramp_nxt    = 4'h0;
      armed_nxt   = 1'b1;
    end else if (step_in) begin
      if (len == 8'h00 || elapsed_r + 8'h01 >= len) begin
        case (region_r)
          REG_A1:  region_nxt = REG_B1;
          REG_B1:  region_nxt = REG_C1;
          REG_C1:  region_nxt = REG_D;
          REG_D:   region_nxt = REG_A2;
          REG_A2:  region_nxt = REG_B2;
          REG_B2:  region_nxt = REG_C2;
          REG_C2:  region_nxt = REG_E;
          default: region_nxt = REG_A1;
        endcase
        elapsed_nxt = 8'h00;
        acc_nxt     = 8'h00;
        ramp_nxt    = 4'h0;
        // generator keeps cycling after the stop; only the outputs detach
        if (armed_r && oneshot_in) begin
          stop_nxt      = 1'b1;
          armed_nxt     = 1'b0;
          stop_peak_nxt = (region_r == REG_A1) || (region_r == REG_A2) ||
                          (region_r == REG_B1) || (region_r == REG_B2);
        end
      end else begin
        elapsed_nxt = elapsed_r + 8'h01;
        acc_nxt     = acc_r + {4'h0, peak_in};
        if (acc_nxt >= len) begin
          acc_nxt  = acc_nxt - len;
          ramp_nxt = (ramp_r == LEVEL_FULL) ? ramp_r : ramp_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      region_r      <= REG_A1;
      elapsed_r     <= 8'h00;
      acc_r         <= 8'h00;
      ramp_r        <= 4'h0;
      armed_r       <= 1'b0;
      level_out     <= 4'h0;
      stop_out      <= 1'b0;
      stop_peak_out <= 1'b0;
    end else begin
      region_r      <= region_nxt;
      elapsed_r     <= elapsed_nxt;
      acc_r         <= acc_nxt;
      ramp_r        <= ramp_nxt;
      armed_r       <= armed_nxt;
      level_out     <= level_nxt;
      stop_out      <= stop_nxt;
      stop_peak_out <= stop_peak_nxt;
    end
  end
endmodule : bank_sequencer

// ===== hdl/led_bank_ctrl.sv
`timescale 1ns/1ns
module led_bank_ctrl
  import led_bank_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_TICK_CYCLES,
  parameter int STEP_DIV = STEP_TICKS
) (
  input  wire logic                   ref_clk_in,       // system clock, 100 MHz
  input  wire logic                   sys_rst_in,       // async reset, high
  input  wire logic                   xfer_start_in,    // pulse: new transaction
  input  wire logic                   wr_byte_valid_in, // pulse: byte written
  input  wire logic [7:0]             wr_byte_in,       // written byte
  input  wire logic                   rd_byte_req_in,   // pulse: byte read
  output logic [7:0]                  rd_byte_out,      // read data
  output logic                        rd_byte_valid_out, // pulse: read data valid
  output logic [NUM_OUTPUTS-1:0]      led_pull_low_out  // open-drain enable, high sinks
);
  logic [7:0] regs_r   [NUM_REGS];
  logic [7:0] regs_nxt [NUM_REGS];
  logic [3:0] ptr_r, ptr_nxt;
  logic       autoinc_r, autoinc_nxt, cmd_wait_r, cmd_wait_nxt;
  logic [7:0] rd_nxt;
  logic       rdv_nxt;
  logic       restart0, restart1;
  logic [3:0] frame_r, frame_nxt;
  logic [NUM_OUTPUTS-1:0] pull_nxt;
  logic       slow_tick, step_tick;
  logic [3:0] level0, level1, peak0, peak1, master;
  logic       stop0, stop1, stop_peak0, stop_peak1;
  logic [7:0] restart_byte;

  assign master = regs_r[ADDR_ONESHOT][MASTER_LSB +: 4];
  assign peak0  = peak_pick(regs_r[ADDR_ONESHOT][SRC_SEL_BIT0],
                            regs_r[ADDR_PEAK][3:0], master);
  assign peak1  = peak_pick(regs_r[ADDR_ONESHOT][SRC_SEL_BIT0 + 1],
                            regs_r[ADDR_PEAK][GROUP_ONE_LSB +: 4], master);
  assign restart_byte = wr_byte_in;

  tick_divider #(
    .SLOW_DIV (SLOW_DIV),
    .STEP_DIV (STEP_DIV)
  ) u_ticks (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .slow_tick_out (slow_tick),
    .step_tick_out (step_tick)
  );

  bank_sequencer u_group_zero (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .step_in       (step_tick),
    .restart_in    (restart0),
    .start_code_in (restart_byte[RESTART_LSB0 +: 3]),
    .oneshot_in    (regs_r[ADDR_ONESHOT][MODE_BIT0]),
    .fade_up_in    (regs_r[ADDR_FADE_UP][3:0]),
    .full_on_in    (regs_r[ADDR_FULL_ON][3:0]),
    .fade_down_in  (regs_r[ADDR_FADE_DOWN][3:0]),
    .off_one_in    (regs_r[ADDR_OFF_ONE][3:0]),
    .off_two_in    (regs_r[ADDR_OFF_TWO][3:0]),
    .peak_in       (peak0),
    .level_out     (level0),
    .stop_out      (stop0),
    .stop_peak_out (stop_peak0)
  );

  // group one is the same sequencer with its own nibbles and bits
  bank_sequencer u_group_one (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .step_in       (step_tick),
    .restart_in    (restart1),
    .start_code_in (restart_byte[RESTART_LSB1 +: 3]),
    .oneshot_in    (regs_r[ADDR_ONESHOT][MODE_BIT0 + 1]),
    .fade_up_in    (regs_r[ADDR_FADE_UP][GROUP_ONE_LSB +: 4]),
    .full_on_in    (regs_r[ADDR_FULL_ON][GROUP_ONE_LSB +: 4]),
    .fade_down_in  (regs_r[ADDR_FADE_DOWN][GROUP_ONE_LSB +: 4]),
    .off_one_in    (regs_r[ADDR_OFF_ONE][GROUP_ONE_LSB +: 4]),
    .off_two_in    (regs_r[ADDR_OFF_TWO][GROUP_ONE_LSB +: 4]),
    .peak_in       (peak1),
    .level_out     (level1),
    .stop_out      (stop1),
    .stop_peak_out (stop_peak1)
  );

  function automatic logic [3:0] out_level(input logic [2:0] code, input logic [3:0] w0,
                                            input logic [3:0] w1, input logic [3:0] p0,
                                            input logic [3:0] p1);
    case (code)
      OUT_WAVE0:        out_level = w0;
      OUT_WAVE1:        out_level = w1;
      OUT_PEAK0:        out_level = p0;
      OUT_PEAK1:        out_level = p1;
      OUT_ON, OUT_ON_B: out_level = LEVEL_FULL;
      default:          out_level = 4'h0;
    endcase
  endfunction : out_level

  // register access over the byte stream
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    ptr_nxt      = ptr_r;
    autoinc_nxt  = autoinc_r;
    cmd_wait_nxt = cmd_wait_r;
    rd_nxt       = rd_byte_out;
    rdv_nxt      = 1'b0;
    restart0     = 1'b0;
    restart1     = 1'b0;
    if (xfer_start_in) begin
      cmd_wait_nxt = 1'b1;
    end else if (wr_byte_valid_in && cmd_wait_r) begin
      ptr_nxt      = wr_byte_in[3:0];
      autoinc_nxt  = wr_byte_in[CMD_AUTOINC];
      cmd_wait_nxt = 1'b0;
    end else if (wr_byte_valid_in) begin
      if (ptr_r < 4'(NUM_REGS)) begin
        regs_nxt[ptr_r] = wr_byte_in;
      end
      if (ptr_r == ADDR_RESTART) begin
        restart0 = wr_byte_in[RESTART_REQ0];
        restart1 = wr_byte_in[RESTART_REQ1];
      end
      if (autoinc_r) begin
        ptr_nxt = (ptr_r >= ADDR_RESTART) ? ADDR_SEL_A : ptr_r + 4'h1;
      end
    end else if (rd_byte_req_in) begin
      rd_nxt  = (ptr_r < 4'(NUM_REGS)) ? regs_r[ptr_r] : 8'h00;
      rdv_nxt = 1'b1;
      if (autoinc_r) begin
        ptr_nxt = (ptr_r >= ADDR_RESTART) ? ADDR_SEL_A : ptr_r + 4'h1;
      end
    end
    // one-shot stop detaches its outputs; the hardware update wins a same-cycle write
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      if (stop0 && {regs_nxt[ADDR_SEL_C][i], regs_nxt[ADDR_SEL_B][i],
                    regs_nxt[ADDR_SEL_A][i]} == OUT_WAVE0) begin
        regs_nxt[ADDR_SEL_C][i] = 1'b0;
        regs_nxt[ADDR_SEL_B][i] = stop_peak0;
      end
      if (stop1 && {regs_nxt[ADDR_SEL_C][i], regs_nxt[ADDR_SEL_B][i],
                    regs_nxt[ADDR_SEL_A][i]} == OUT_WAVE1) begin
        regs_nxt[ADDR_SEL_C][i] = 1'b0;
        regs_nxt[ADDR_SEL_B][i] = stop_peak1;
        regs_nxt[ADDR_SEL_A][i] = stop_peak1;
      end
    end
  end

  // duty frame of fifteen slow ticks; the level sinks for that many of them
  always_comb begin
    frame_nxt = frame_r;
    if (slow_tick) begin
      frame_nxt = (frame_r == PWM_STEPS - 4'h1) ? 4'h0 : frame_r + 4'h1;
    end
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      pull_nxt[i] = frame_r < out_level({regs_r[ADDR_SEL_C][i], regs_r[ADDR_SEL_B][i],
                                         regs_r[ADDR_SEL_A][i]},
                                        level0, level1, peak0, peak1);
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      regs_r[ADDR_SEL_A]     <= RST_SEL;
      regs_r[ADDR_SEL_B]     <= RST_SEL;
      regs_r[ADDR_SEL_C]     <= RST_SEL;
      regs_r[ADDR_FADE_UP]   <= RST_DURATION;
      regs_r[ADDR_FULL_ON]   <= RST_DURATION;
      regs_r[ADDR_FADE_DOWN] <= RST_DURATION;
      regs_r[ADDR_OFF_ONE]   <= RST_DURATION;
      regs_r[ADDR_OFF_TWO]   <= RST_DURATION;
      regs_r[ADDR_PEAK]      <= RST_PEAK;
      regs_r[ADDR_ONESHOT]   <= RST_ONESHOT;
      regs_r[ADDR_RESTART]   <= RST_RESTART;
      ptr_r             <= 4'h0;
      autoinc_r         <= 1'b0;
      cmd_wait_r        <= 1'b0;
      rd_byte_out       <= 8'h00;
      rd_byte_valid_out <= 1'b0;
      frame_r           <= 4'h0;
      led_pull_low_out  <= '0;
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
      ptr_r             <= ptr_nxt;
      autoinc_r         <= autoinc_nxt;
      cmd_wait_r        <= cmd_wait_nxt;
      rd_byte_out       <= rd_nxt;
      rd_byte_valid_out <= rdv_nxt;
      frame_r           <= frame_nxt;
      led_pull_low_out  <= pull_nxt;
    end
  end
endmodule : led_bank_ctrl

// ===== hdl/led_bank_pkg.sv
package led_bank_pkg;
  localparam int NUM_OUTPUTS = 7;
  localparam int NUM_REGS    = 11;

  localparam logic [3:0] ADDR_SEL_A     = 4'h0;
  localparam logic [3:0] ADDR_SEL_B     = 4'h1;
  localparam logic [3:0] ADDR_SEL_C     = 4'h2;
  localparam logic [3:0] ADDR_FADE_UP   = 4'h3;
  localparam logic [3:0] ADDR_FULL_ON   = 4'h4;
  localparam logic [3:0] ADDR_FADE_DOWN = 4'h5;
  localparam logic [3:0] ADDR_OFF_ONE   = 4'h6;
  localparam logic [3:0] ADDR_OFF_TWO   = 4'h7;
  localparam logic [3:0] ADDR_PEAK      = 4'h8;
  localparam logic [3:0] ADDR_ONESHOT   = 4'h9;
  localparam logic [3:0] ADDR_RESTART   = 4'ha;

  localparam logic [7:0] RST_SEL      = 8'h00;
  localparam logic [7:0] RST_DURATION = 8'h44;
  localparam logic [7:0] RST_PEAK     = 8'hff;
  localparam logic [7:0] RST_ONESHOT  = 8'h00;
  localparam logic [7:0] RST_RESTART  = 8'h00;

  localparam int MASTER_LSB     = 0;
  localparam int SRC_SEL_BIT0   = 4;
  localparam int MODE_BIT0      = 6;
  localparam int RESTART_LSB0   = 0;
  localparam int RESTART_REQ0   = 3;
  localparam int RESTART_LSB1   = 4;
  localparam int RESTART_REQ1   = 7;
  localparam int CMD_AUTOINC    = 4;
  localparam int GROUP_ONE_LSB  = 4;

  localparam int CLK_HZ           = 100_000_000;
  localparam int SLOW_CLK_HZ      = 32_000;
  localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_CLK_HZ;
  localparam int UPDATE_RATE_HZ   = 125;
  localparam int STEP_TICKS       = SLOW_CLK_HZ / UPDATE_RATE_HZ;
  localparam logic [3:0] PWM_STEPS      = 4'hf;
  localparam logic [7:0] STEPS_PER_CODE = 8'h08;
  localparam logic [3:0] LEVEL_FULL     = 4'hf;

  // per output select code {c,b,a}
  localparam logic [2:0] OUT_OFF   = 3'h0;
  localparam logic [2:0] OUT_OFF_B = 3'h1;
  localparam logic [2:0] OUT_PEAK0 = 3'h2;
  localparam logic [2:0] OUT_PEAK1 = 3'h3;
  localparam logic [2:0] OUT_ON    = 3'h4;
  localparam logic [2:0] OUT_ON_B  = 3'h5;
  localparam logic [2:0] OUT_WAVE0 = 3'h6;
  localparam logic [2:0] OUT_WAVE1 = 3'h7;

  typedef enum logic [7:0] {
    REG_A1 = 8'h01,
    REG_B1 = 8'h02,
    REG_C1 = 8'h04,
    REG_D  = 8'h08,
    REG_A2 = 8'h10,
    REG_B2 = 8'h20,
    REG_C2 = 8'h40,
    REG_E  = 8'h80
  } region_t;

  function automatic logic [3:0] peak_pick(input logic use_master, input logic [3:0] own,
                                            input logic [3:0] master);
    peak_pick = use_master ? master : own;
  endfunction : peak_pick
endpackage : led_bank_pkg

// ===== hdl/tick_divider.sv
`timescale 1ns/1ns
module tick_divider
  import led_bank_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_TICK_CYCLES,
  parameter int STEP_DIV = STEP_TICKS
) (
  input  wire logic ref_clk_in,   // system clock
  input  wire logic sys_rst_in,   // async reset, high
  output logic      slow_tick_out, // one pulse per slow clock period
  output logic      step_tick_out  // one pulse per intensity update
);
  logic [15:0] div_r, div_nxt;
  logic [15:0] step_r, step_nxt;
  logic        slow_nxt, stepp_nxt;

  always_comb begin
    div_nxt   = div_r + 16'h0001;
    step_nxt  = step_r;
    slow_nxt  = 1'b0;
    stepp_nxt = 1'b0;
    if (div_r == 16'(SLOW_DIV - 1)) begin
      div_nxt  = 16'h0000;
      slow_nxt = 1'b1;
      step_nxt = step_r + 16'h0001;
      if (step_r == 16'(STEP_DIV - 1)) begin
        step_nxt  = 16'h0000;
        stepp_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_r         <= 16'h0000;
      step_r        <= 16'h0000;
      slow_tick_out <= 1'b0;
      step_tick_out <= 1'b0;
    end else begin
      div_r         <= div_nxt;
      step_r        <= step_nxt;
      slow_tick_out <= slow_nxt;
      step_tick_out <= stepp_nxt;
    end
  end
endmodule : tick_divider

// ===== tb/controller_model.sv
`timescale 1ns/1ns
module controller_model (
  input  wire logic       ref_clk_in,        // system clock
  input  wire logic [7:0] rd_byte_in,        // read data
  input  wire logic       rd_byte_valid_in,  // read data fresh
  output logic            xfer_start_out,    // transaction start
  output logic            wr_byte_valid_out, // byte written
  output logic [7:0]      wr_byte_out,       // written byte
  output logic            rd_byte_req_out    // byte read request
);
  int gap = 0;  // idle cycles before each request, for a slow master

  initial begin
    xfer_start_out    = 1'b0;
    wr_byte_valid_out = 1'b0;
    wr_byte_out       = 8'h00;
    rd_byte_req_out   = 1'b0;
  end

  task automatic put_byte(input logic [7:0] b);
    repeat (gap) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    wr_byte_valid_out <= 1'b1;
    wr_byte_out       <= b;
    @(posedge ref_clk_in);
    wr_byte_valid_out <= 1'b0;
    wr_byte_out       <= ~b;  // released bus must not keep the last byte
  endtask : put_byte

  // first byte after a start is the command; 0x10 walks writes up from address zero
  task automatic send_cmd(input logic [7:0] cmd);
    repeat (gap) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    xfer_start_out <= 1'b1;
    @(posedge ref_clk_in);
    xfer_start_out <= 1'b0;
    put_byte(cmd);
  endtask : send_cmd

  task automatic get_byte(output logic [7:0] d, output logic v);
    repeat (gap) @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    rd_byte_req_out <= 1'b1;
    @(posedge ref_clk_in);
    rd_byte_req_out <= 1'b0;
    #1;
    d = rd_byte_in;
    v = rd_byte_valid_in;
  endtask : get_byte
endmodule : controller_model

// ===== tb/led_bank_ctrl_asserts.sv
`timescale 1ns/1ns
module led_bank_ctrl_asserts
  import led_bank_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_TICK_CYCLES,
  parameter int STEP_DIV = STEP_TICKS
) (
  input wire logic                   ref_clk_in,        // system clock
  input wire logic                   sys_rst_in,        // async reset, high
  input wire logic                   xfer_start_in,     // transaction start
  input wire logic                   wr_byte_valid_in,  // byte written
  input wire logic [7:0]             wr_byte_in,        // written byte
  input wire logic                   rd_byte_req_in,    // byte read request
  input wire logic [7:0]             rd_byte_out,       // read data
  input wire logic                   rd_byte_valid_out, // read data fresh
  input wire logic [NUM_OUTPUTS-1:0] led_pull_low_out   // pin sink enables
);
  logic [7:0] shadow_r   [NUM_REGS];
  logic [7:0] shadow_nxt [NUM_REGS];
  logic [7:0] exp_r, exp_nxt;
  logic [3:0] ptr_r, ptr_nxt;
  logic       ai_r, ai_nxt, cmd_r, cmd_nxt;
  logic       wr_take, rd_take;

  assign wr_take = wr_byte_valid_in && !xfer_start_in;
  assign rd_take = rd_byte_req_in && !xfer_start_in && !wr_byte_valid_in;

  // shadow of every register; select readbacks go unchecked as hardware rewrites them
  always_comb begin
    shadow_nxt = shadow_r;
    ptr_nxt    = ptr_r;
    ai_nxt     = ai_r;
    cmd_nxt    = cmd_r;
    exp_nxt    = (ptr_r <= ADDR_RESTART) ? shadow_r[ptr_r] : 8'h00;
    if (xfer_start_in) begin
      cmd_nxt = 1'b1;
    end else if (wr_take && cmd_r) begin
      cmd_nxt = 1'b0;
      ptr_nxt = wr_byte_in[3:0];
      ai_nxt  = wr_byte_in[CMD_AUTOINC];
    end else if (wr_take || rd_take) begin
      if (wr_take && ptr_r <= ADDR_RESTART) begin
        shadow_nxt[ptr_r] = wr_byte_in;
      end
      if (ai_r) begin
        ptr_nxt = (ptr_r >= ADDR_RESTART) ? 4'h0 : ptr_r + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      shadow_r <= '{RST_SEL, RST_SEL, RST_SEL, RST_DURATION, RST_DURATION, RST_DURATION,
                    RST_DURATION, RST_DURATION, RST_PEAK, RST_ONESHOT, RST_RESTART};
      exp_r    <= 8'h00;
      ptr_r    <= 4'h0;
      ai_r     <= 1'b0;
      cmd_r    <= 1'b0;
    end else begin
      shadow_r <= shadow_nxt;
      exp_r    <= exp_nxt;
      ptr_r    <= ptr_nxt;
      ai_r     <= ai_nxt;
      cmd_r    <= cmd_nxt;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_rd_at(logic [3:0] a);
    rd_take && ptr_r == a;
  endsequence
  sequence s_rd_dur;
    rd_take && ptr_r >= ADDR_FADE_UP && ptr_r <= ADDR_OFF_TWO;
  endsequence

  property p_rd_lat;      rd_take |=> rd_byte_valid_out;                      endproperty
  property p_rd_quiet;    !rd_take |=> !rd_byte_valid_out;                    endproperty
  property p_rd_hold;     !rd_byte_valid_out |-> $stable(rd_byte_out);        endproperty
  property p_reg_peak;    s_rd_at(ADDR_PEAK) |=> rd_byte_out == exp_r;        endproperty
  property p_reg_master;  s_rd_at(ADDR_ONESHOT) |=> rd_byte_out == exp_r;     endproperty
  property p_reg_restart; s_rd_at(ADDR_RESTART) |=> rd_byte_out == exp_r;     endproperty
  property p_reg_dur;     s_rd_dur |=> rd_byte_out == exp_r;                  endproperty
  property p_reg_gap;     rd_take && ptr_r > ADDR_RESTART |=> rd_byte_out == 8'h00; endproperty

  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer missing one cycle after request");
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read valid without a request");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  a_reg_peak: assert property (p_reg_peak)
    else $error("peak register readback wrong");
  a_reg_master: assert property (p_reg_master)
    else $error("master register readback wrong");
  a_reg_restart: assert property (p_reg_restart)
    else $error("restart register readback wrong");
  a_reg_dur: assert property (p_reg_dur)
    else $error("duration register readback wrong");
  a_reg_gap: assert property (p_reg_gap)
    else $error("unmapped address read not zero");
endmodule : led_bank_ctrl_asserts

bind led_bank_ctrl led_bank_ctrl_asserts #(.SLOW_DIV(SLOW_DIV), .STEP_DIV(STEP_DIV))
  i_led_bank_ctrl_asserts (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .xfer_start_in(xfer_start_in),
  .wr_byte_valid_in(wr_byte_valid_in), .wr_byte_in(wr_byte_in),
  .rd_byte_req_in(rd_byte_req_in), .rd_byte_out(rd_byte_out),
  .rd_byte_valid_out(rd_byte_valid_out), .led_pull_low_out(led_pull_low_out));

// ===== tb/led_bank_ctrl_bench.sv
`timescale 1ns/1ns
module led_bank_ctrl_bench;
  import led_bank_pkg::*;
  localparam int SD        = 4;
  localparam int ST        = 4;
  localparam int FRAME     = 15 * SD;
  localparam int STOP_WAIT = 12 * ST * SD;  // one nibble-1 region plus margin

  logic                   ref_clk_in = 1'b0;
  logic                   sys_rst_in = 1'b1;
  logic                   xfer_start, wr_byte_valid, rd_byte_req, rd_byte_valid;
  logic [7:0]             wr_byte, rd_byte;
  logic [NUM_OUTPUTS-1:0] led_pull_low;
  int                     mismatches = 0;
  int                     compares = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  led_bank_ctrl #(.SLOW_DIV(SD), .STEP_DIV(ST)) i_led_bank_ctrl (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .xfer_start_in(xfer_start),
    .wr_byte_valid_in(wr_byte_valid), .wr_byte_in(wr_byte), .rd_byte_req_in(rd_byte_req),
    .rd_byte_out(rd_byte), .rd_byte_valid_out(rd_byte_valid), .led_pull_low_out(led_pull_low));

  controller_model i_controller_model (
    .ref_clk_in(ref_clk_in), .rd_byte_in(rd_byte), .rd_byte_valid_in(rd_byte_valid),
    .xfer_start_out(xfer_start), .wr_byte_valid_out(wr_byte_valid), .wr_byte_out(wr_byte),
    .rd_byte_req_out(rd_byte_req));

  task automatic test_done;
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk_n(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_n

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_controller_model.send_cmd({4'h0, a});
    i_controller_model.put_byte(d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_controller_model.send_cmd({4'h0, a});
    i_controller_model.get_byte(d, v);
    chk8("read valid", 8'h01, {7'h0, v});
    chk8("register read", exp, d);
  endtask : rd

  // frame counter runs free, so any window of one frame holds level * SD sink cycles
  task automatic duty(input int idx, input int lvl);
    int n;
    n = 0;
    repeat (4) @(posedge ref_clk_in);
    repeat (FRAME) begin
      @(posedge ref_clk_in);
      #1;
      if (led_pull_low[idx] === 1'b1) n++;
    end
    chk_n("sink cycles per frame", lvl * SD, n);
  endtask : duty

  task automatic t_reset_vals;
    logic [7:0] rv [NUM_REGS];
    logic [7:0] d;
    logic       v;
    rv = '{RST_SEL, RST_SEL, RST_SEL, RST_DURATION, RST_DURATION, RST_DURATION,
           RST_DURATION, RST_DURATION, RST_PEAK, RST_ONESHOT, RST_RESTART};
    i_controller_model.send_cmd(8'h10);
    for (int i = 0; i < NUM_REGS; i++) begin
      i_controller_model.get_byte(d, v);
      chk8("reset value", rv[i], d);
    end
    wr(4'hb, 8'h5a);
    rd(4'hb, 8'h00);
  endtask : t_reset_vals

  task automatic t_autoinc;
    logic [7:0] wv [NUM_REGS];
    logic [7:0] d;
    logic       v;
    wv = '{8'h00, 8'h00, 8'h00, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h3a, 8'h05, 8'h77};
    i_controller_model.gap = 2;
    i_controller_model.send_cmd(8'h10);
    for (int i = 0; i < NUM_REGS; i++) begin
      i_controller_model.put_byte(wv[i]);
    end
    i_controller_model.gap = 0;
    i_controller_model.send_cmd(8'h10);
    for (int i = 0; i < NUM_REGS; i++) begin
      i_controller_model.get_byte(d, v);
      chk8("auto-increment readback", wv[i], d);
    end
  endtask : t_autoinc

  task automatic t_master;
    logic [7:0] mv [6];
    int         e0 [6];
    int         e1 [6];
    mv = '{8'h05, 8'h15, 8'h35, 8'h3f, 8'h30, 8'h27};
    e0 = '{10, 5, 5, 15, 0, 10};
    e1 = '{3, 3, 5, 15, 0, 7};
    wr(ADDR_SEL_A, 8'h02);
    wr(ADDR_SEL_B, 8'h03);
    wr(ADDR_SEL_C, 8'h44);
    duty(2, 15);
    duty(6, 15);
    duty(3, 0);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_ONESHOT, mv[i]);
      rd(ADDR_ONESHOT, mv[i]);
      duty(0, e0[i]);
      duty(1, e1[i]);
    end
  endtask : t_master

  task automatic t_oneshot;
    logic [2:0] c1;
    logic       h0, h1;
    wr(ADDR_ONESHOT, 8'hc0);
    for (int c = 0; c < 8; c++) begin
      c1 = 3'h7 - c[2:0];
      h0 = ~c[1];
      h1 = ~c1[1];
      i_controller_model.send_cmd(8'h10);
      i_controller_model.put_byte(8'h20);
      i_controller_model.put_byte(8'h30);
      i_controller_model.put_byte(8'h30);
      wr(ADDR_RESTART, {1'b1, c1, 1'b1, c[2:0]});
      rd(ADDR_SEL_C, 8'h30);
      // a stray restart here would move the stop into an off region and clear the peak state
      wr(ADDR_RESTART, 8'h77);
      repeat (STOP_WAIT) @(posedge ref_clk_in);
      rd(ADDR_SEL_A, h1 ? 8'h20 : 8'h00);
      rd(ADDR_SEL_B, {2'h0, h1, h0, 4'h0});
      rd(ADDR_SEL_C, 8'h00);
      duty(4, h0 ? 10 : 0);
      duty(5, h1 ? 3 : 0);
    end
  endtask : t_oneshot

  initial begin
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    t_reset_vals();
    t_autoinc();
    t_master();
    t_oneshot();
    sys_rst_in <= 1'b1;
    repeat (16) @(posedge ref_clk_in);
    chk8("sinks in reset", 8'h00, {1'b0, led_pull_low});
    sys_rst_in <= 1'b0;
    t_reset_vals();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge ref_clk_in);
    mismatches++;
    test_done();
  end
endmodule : led_bank_ctrl_bench
